/* File: logic/exception_pend_pkg.sv */
// Constants shared by the exception pending control slice
package exception_pend_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] INT_CTRL_OFFSET = 12'hD04;
    localparam logic [11:0] EVT_STATUS_OFFSET = 12'h010;
    localparam logic [11:0] EVT_MASK_OFFSET = 12'h014;

    // ************************************************************
    // Field positions of interrupt_control_state
    // ************************************************************
    localparam int SVC_SET_BIT = 28;
    localparam int SVC_CLR_BIT = 27;
    localparam int TICK_SET_BIT = 26;
    localparam int TICK_CLR_BIT = 25;
    localparam int RSVD_HI_BIT = 24;
    localparam int DBG_PREEMPT_BIT = 23;
    localparam int ANY_IRQ_BIT = 22;
    localparam int RSVD_LO_MSB = 21;
    localparam int RSVD_LO_LSB = 18;

    // ************************************************************
    // Event status layout and reset values
    // ************************************************************
    localparam int EVT_W = 3;
    localparam int EVT_TICK = 0;
    localparam int EVT_SVC = 1;
    localparam int EVT_IRQ = 2;
    localparam logic [2:0] EVT_STATUS_RESET = 3'h0;
    localparam logic [2:0] EVT_MASK_RESET = 3'h0;
    localparam logic PENDING_RESET = 1'h0;
    localparam int NUM_PERIPH_IRQ = 30;

    // ************************************************************
    // Bus answers
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [3:0] FULL_STRB = 4'hF;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    // Word hit on a register offset
    function automatic logic regHit(input logic [11:0] addr,
                                    input logic [11:0] offset);
        regHit = (addr[11:2] == offset[11:2]);
    endfunction : regHit

    // Privileged, word aligned access
    function automatic logic accessOk(input logic [11:0] addr,
                                      input logic privileged);
        accessOk = privileged && (addr[1:0] == 2'h0);
    endfunction : accessOk

endpackage : exception_pend_pkg

/* File: logic/pending_state.sv */
// One exception pending flag with set and clear
`timescale 1ns/1ps
`default_nettype none
module pending_state
    import exception_pend_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Requests
    input wire logic setReq,
    input wire logic clrReq,
    // State
    output logic pending_q
);

    logic pending_d;

    // Set wins so a new request is never lost
    assign pending_d = setReq ? 1'b1 : (clrReq ? 1'b0 : pending_q);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pending_q <= PENDING_RESET;
        else
            pending_q <= pending_d;
    end

endmodule : pending_state
`default_nettype wire

/* File: logic/event_status.sv */
// Sticky event status with mask and one interrupt level
`timescale 1ns/1ps
`default_nettype none
module event_status
    import exception_pend_pkg::*;
#(
    parameter int W = EVT_W
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Events and software access
    input wire logic [W-1:0] evt,
    input wire logic statusWr,
    input wire logic maskWr,
    input wire logic [W-1:0] wrData,
    // State
    output logic [W-1:0] status_q,
    output logic [W-1:0] mask_q,
    output logic irq_q
);

    logic [W-1:0] status_d;
    logic [W-1:0] clrBits;

    assign clrBits = statusWr ? wrData : '0;
    // Event in the clearing cycle survives
    assign status_d = evt | (status_q & ~clrBits);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_q <= W'(EVT_STATUS_RESET);
            mask_q <= W'(EVT_MASK_RESET);
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            if (maskWr)
                mask_q <= wrData;
            irq_q <= |(status_q & mask_q);
        end
    end

endmodule : event_status
`default_nettype wire

/* File: logic/exception_pend_control_status.sv */
// Pending control and status slice of the interrupt control register
//
// Behaviour
// - A one written to bit 27 clears the service call pending state.
// - Bit 26 reads back whether the tick exception is pending.
// - A one written to bit 26 makes the tick exception pending.
// - Writing a one to bit 25 makes bit 26 read zero again.
// - A one written to bit 25 clears the tick pending state.
// - Bit 24 and bits 21:18 read zero and software keeps them.
// - Bit 23 shows whether leaving debug halt will take an interrupt.
// - Bit 23 reads zero whenever the core is not in debug mode.
// - Bit 22 reads one while any peripheral interrupt is pending.
// - Bit 22 looks only at peripheral interrupts, not NMI or faults.
// - Only a software write to bit 28 pends the service call.
// - Only privileged aligned word accesses reach the register.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module exception_pend_control_status
    import exception_pend_pkg::*;
#(
    parameter int NUM_IRQ = NUM_PERIPH_IRQ
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core side status
    input wire logic [NUM_IRQ-1:0] periphIrqPending,
    input wire logic debugHalted,
    input wire logic releaseTakesIrq,
    // Core side exception events
    input wire logic tickEvent,
    input wire logic serviceAck,
    input wire logic tickAck,
    // Pending state and interrupt
    output logic servicePending,
    output logic tickPending,
    output logic irq
);

    // ************************************************************
    // Write channel capture
    // ************************************************************
    logic awHeld_q;
    logic wHeld_q;
    logic [11:0] awAddr_q;
    logic awPriv_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bValid_q;
    logic [1:0] bResp_q;
    logic doWrite;

    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready = !wHeld_q && !bValid_q;
    assign doWrite = awHeld_q && wHeld_q && !bValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awHeld_q <= 1'b0;
            awAddr_q <= 12'h000;
            awPriv_q <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
            awPriv_q <= s_axi_awprot[0];
        end
        else if (doWrite)
            awHeld_q <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end
        else if (doWrite)
            wHeld_q <= 1'b0;
    end

    // ************************************************************
    // Write decode
    // ************************************************************
    logic wrHitCtrl;
    logic wrHitStatus;
    logic wrHitMask;
    logic wrMapped;
    logic wrAllowed;
    logic [1:0] wrResp;

    assign wrHitCtrl = regHit(awAddr_q, INT_CTRL_OFFSET);
    assign wrHitStatus = regHit(awAddr_q, EVT_STATUS_OFFSET);
    assign wrHitMask = regHit(awAddr_q, EVT_MASK_OFFSET);
    assign wrMapped = wrHitCtrl || wrHitStatus || wrHitMask;
    // Word access from privileged code only
    // privilege and alignment
    assign wrAllowed = accessOk(awAddr_q, awPriv_q)
        && (wStrb_q == FULL_STRB);
    assign wrResp = !wrMapped ? RESP_DECERR
        : (wrAllowed ? RESP_OKAY : RESP_SLVERR);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bValid_q <= 1'b0;
            bResp_q <= RESP_OKAY;
        end
        else if (doWrite)
        begin
            bValid_q <= 1'b1;
            bResp_q <= wrResp;
        end
        else if (s_axi_bready)
            bValid_q <= 1'b0;
    end

    // ************************************************************
    // Pending state of the two exceptions
    // ************************************************************
    logic ctrlWr;
    logic swSvcSet;
    logic swSvcClr;
    logic swTickSet;
    logic swTickClr;
    logic svcSetReq;
    logic svcClrReq;
    logic tickSetReq;
    logic tickClrReq;
    logic svcPending_q;
    logic tickPending_q;

    assign ctrlWr = doWrite && wrHitCtrl && wrAllowed;
    assign swSvcSet = ctrlWr && wData_q[SVC_SET_BIT];
    assign swSvcClr = ctrlWr && wData_q[SVC_CLR_BIT];
    assign swTickSet = ctrlWr && wData_q[TICK_SET_BIT];
    assign swTickClr = ctrlWr && wData_q[TICK_CLR_BIT];

    // Both set and clear at once is left to the set
    // conflicting writes resolved
    assign svcSetReq = swSvcSet;
    assign svcClrReq = swSvcClr || serviceAck;
    assign tickSetReq = swTickSet || tickEvent;
    assign tickClrReq = swTickClr || tickAck;

    pending_state svcState
    (
        .core_clk (core_clk),
        .rst_n (rst_n),
        .setReq (svcSetReq),
        .clrReq (svcClrReq),
        .pending_q (svcPending_q)
    );

    pending_state tickState
    (
        .core_clk (core_clk),
        .rst_n (rst_n),
        .setReq (tickSetReq),
        .clrReq (tickClrReq),
        .pending_q (tickPending_q)
    );

    assign servicePending = svcPending_q;
    assign tickPending = tickPending_q;

    // ************************************************************
    // Status bits of the slice
    // ************************************************************
    logic anyIrq;
    logic dbgPreempt;
    logic anyIrqPrev_q;

    // NMI and faults never reach this vector
    // peripheral interrupts only
    assign anyIrq = |periphIrqPending;
    assign dbgPreempt = debugHalted && releaseTakesIrq;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            anyIrqPrev_q <= 1'b0;
        else
            anyIrqPrev_q <= anyIrq;
    end

    // ************************************************************
    // Event status, mask and interrupt
    // ************************************************************
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] evtStatus_q;
    logic [EVT_W-1:0] evtMask_q;
    logic statusWr;
    logic maskWr;

    assign evt[EVT_TICK] = tickSetReq && !tickPending_q;
    assign evt[EVT_SVC] = svcSetReq && !svcPending_q;
    assign evt[EVT_IRQ] = anyIrq && !anyIrqPrev_q;
    assign statusWr = doWrite && wrHitStatus && wrAllowed;
    assign maskWr = doWrite && wrHitMask && wrAllowed;

    event_status #(.W(EVT_W)) events
    (
        .core_clk (core_clk),
        .rst_n (rst_n),
        .evt (evt),
        .statusWr (statusWr),
        .maskWr (maskWr),
        .wrData (wData_q[EVT_W-1:0]),
        .status_q (evtStatus_q),
        .mask_q (evtMask_q),
        .irq_q (irq)
    );

    // ************************************************************
    // Read path
    // ************************************************************
    logic rdHitCtrl;
    logic rdHitStatus;
    logic rdHitMask;
    logic rdMapped;
    logic rdAllowed;
    logic [31:0] ctrlWord;
    logic [31:0] rdWord;
    logic [1:0] rdResp;
    logic rValid_q;
    logic [31:0] rData_q;
    logic [1:0] rResp_q;

    // Clear bits read zero, as do all bits outside the slice
    always_comb
    begin
        ctrlWord = READ_ZERO;
        ctrlWord[SVC_SET_BIT] = svcPending_q;
        ctrlWord[TICK_SET_BIT] = tickPending_q;
        ctrlWord[DBG_PREEMPT_BIT] = dbgPreempt;
        ctrlWord[ANY_IRQ_BIT] = anyIrq;
        ctrlWord[RSVD_HI_BIT] = 1'b0;
        ctrlWord[RSVD_LO_MSB:RSVD_LO_LSB] = 4'h0;
    end

    assign rdHitCtrl = regHit(s_axi_araddr, INT_CTRL_OFFSET);
    assign rdHitStatus = regHit(s_axi_araddr, EVT_STATUS_OFFSET);
    assign rdHitMask = regHit(s_axi_araddr, EVT_MASK_OFFSET);
    assign rdMapped = rdHitCtrl || rdHitStatus || rdHitMask;
    assign rdAllowed = accessOk(s_axi_araddr, s_axi_arprot[0]);
    assign rdWord = !(rdMapped && rdAllowed) ? READ_ZERO
        : rdHitCtrl ? ctrlWord
        : rdHitStatus ? {{(32-EVT_W){1'b0}}, evtStatus_q}
        : {{(32-EVT_W){1'b0}}, evtMask_q};
    assign rdResp = !rdMapped ? RESP_DECERR
        : (rdAllowed ? RESP_OKAY : RESP_SLVERR);

    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rValid_q <= 1'b0;
            rData_q <= READ_ZERO;
            rResp_q <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rValid_q <= 1'b1;
            rData_q <= rdWord;
            rResp_q <= rdResp;
        end
        else if (s_axi_rready)
            rValid_q <= 1'b0;
    end

endmodule : exception_pend_control_status
`default_nettype wire

/* File: verification/exception_pend_props.sv */
// Checker of the exception pending control slice
`timescale 1ns/1ps
`default_nettype none
module exception_pend_props
    import exception_pend_pkg::*;
#(
    parameter int NUM_IRQ = NUM_PERIPH_IRQ
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Write bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    // Read bus
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // Core side
    input wire logic [NUM_IRQ-1:0] periphIrqPending,
    input wire logic debugHalted,
    input wire logic releaseTakesIrq,
    input wire logic tickEvent,
    input wire logic tickAck,
    input wire logic servicePending,
    input wire logic tickPending
);
    logic [11:0] awAddr_q;
    logic awPriv_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;

    // Write is judged at the response, so keep what was taken
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awAddr_q <= 12'h000;
            awPriv_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awAddr_q <= s_axi_awaddr;
                awPriv_q <= s_axi_awprot[0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
        end
    end

    wire logic ctrlWr = (awAddr_q == INT_CTRL_OFFSET) && awPriv_q
        && (wStrb_q == FULL_STRB);
    wire logic rdTake = s_axi_arvalid && s_axi_arready;
    wire logic ctrlRd = rdTake && (s_axi_araddr == INT_CTRL_OFFSET)
        && s_axi_arprot[0];
    wire logic dbgTake = debugHalted && releaseTakesIrq;
    wire logic anyIrq = |periphIrqPending;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    svc_clear_a: assert property (
        $rose(s_axi_bvalid) && ctrlWr && wData_q[27] && !wData_q[28]
        |-> !servicePending) else $error("service clear ignored");
    svc_only_write_a: assert property (
        $rose(servicePending) |-> $rose(s_axi_bvalid) && ctrlWr
        && wData_q[28]) else $error("service pended without write");
    tick_set_a: assert property (
        $rose(s_axi_bvalid) && ctrlWr && wData_q[26]
        |-> tickPending) else $error("tick set ignored");
    tick_clear_a: assert property (
        $rose(s_axi_bvalid) && ctrlWr && wData_q[25] && !wData_q[26]
        && !$past(tickEvent) |-> !tickPending)
        else $error("tick clear ignored");
    tick_zero_write_a: assert property (
        $rose(s_axi_bvalid) && ctrlWr && (wData_q[26:25] == 2'h0)
        && !$past(tickEvent) && !$past(tickAck) |-> $stable(tickPending))
        else $error("zero write moved tick state");
    tick_read_a: assert property (
        ctrlRd |=> s_axi_rvalid && (s_axi_rdata[26] == $past(tickPending)))
        else $error("tick bit read wrong");
    rsvd_zero_a: assert property (
        ctrlRd |=> (s_axi_rdata[24] == 1'b0)
        && (s_axi_rdata[21:18] == 4'h0)) else $error("reserved not zero");
    dbg_bit_a: assert property (
        ctrlRd |=> s_axi_rdata[23] == $past(dbgTake))
        else $error("debug preempt bit wrong");
    any_irq_a: assert property (
        ctrlRd |=> s_axi_rdata[22] == $past(anyIrq))
        else $error("interrupt pending bit wrong");
    unpriv_read_a: assert property (
        rdTake && !s_axi_arprot[0] && (s_axi_araddr == INT_CTRL_OFFSET)
        |=> (s_axi_rresp == RESP_SLVERR)
        && (s_axi_rdata == READ_ZERO)) else $error("unprivileged read ok");
    unpriv_write_a: assert property (
        $rose(s_axi_bvalid) && !awPriv_q |-> s_axi_bresp != RESP_OKAY)
        else $error("unprivileged write ok");
endmodule : exception_pend_props

bind exception_pend_control_status exception_pend_props
    #(.NUM_IRQ(NUM_IRQ)) exception_pend_props_inst (.core_clk, .rst_n,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .periphIrqPending, .debugHalted, .releaseTakesIrq,
    .tickEvent, .tickAck, .servicePending, .tickPending);
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench of the exception pending control slice
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import exception_pend_pkg::*;
();
    typedef struct packed {
        logic [31:0] wd;
        logic dbg;
        logic rel;
        logic [29:0] per;
        logic svc;
        logic tick;
    } row_s;
    logic core_clk, rst_n;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, want;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [29:0] periphIrqPending;
    logic debugHalted, releaseTakesIrq, tickEvent, serviceAck, tickAck;
    logic servicePending, tickPending, irq;
    int badCount = 0;
    int nTests = 0;
    row_s rows [8] = '{
        '{32'h04000000, 1'b0, 1'b1, 30'h0, 1'b0, 1'b1},
        '{32'h10000000, 1'b1, 1'b1, 30'h0, 1'b1, 1'b1},
        '{32'h00000000, 1'b1, 1'b0, 30'h20000000, 1'b1, 1'b1},
        '{32'h08000000, 1'b0, 1'b0, 30'h00000001, 1'b0, 1'b1},
        '{32'h02000000, 1'b0, 1'b0, 30'h0, 1'b0, 1'b0},
        '{32'h01FC0000, 1'b1, 1'b1, 30'h0, 1'b0, 1'b0},
        '{32'h14000000, 1'b0, 1'b0, 30'h3FFFFFFF, 1'b1, 1'b1},
        '{32'h0A000000, 1'b0, 1'b0, 30'h0, 1'b0, 1'b0}};

    exception_pend_control_status exception_pend_control_status_inst (
        .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .periphIrqPending, .debugHalted, .releaseTakesIrq, .tickEvent,
        .serviceAck, .tickAck, .servicePending, .tickPending, .irq);

    always #12.5 core_clk = ~core_clk;

    task automatic check(input string name, input logic [31:0] e,
                         input logic [31:0] g);
        nTests++;
        if (g !== e)
        begin
            badCount++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : check

    task automatic wrReg(input logic [11:0] a, input logic [31:0] d,
                         input logic [2:0] p, output logic [1:0] r);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awprot <= p;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awDone && wDone))
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge core_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wrReg

    task automatic rdReg(input logic [11:0] a, input logic [2:0] p,
                         output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arprot <= p;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge core_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdReg

    task automatic pulse(input int which);
        @(posedge core_clk);
        tickEvent <= (which == 0);
        tickAck <= (which == 1);
        serviceAck <= (which == 2);
        @(posedge core_clk);
        {tickEvent, tickAck, serviceAck} <= 3'h0;
        repeat (2) @(posedge core_clk);
    endtask : pulse

    task automatic endSim;
        $display("Checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : endSim

    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {periphIrqPending, debugHalted, releaseTakesIrq} = '0;
        {tickEvent, serviceAck, tickAck} = 3'h0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rdReg(INT_CTRL_OFFSET, 3'h1, rd, rsp);
        check("reset ctrl", 32'h0, rd & 32'h15FC0000);
        // ****
        // Table of ordinary writes and read-backs
        // ****
        foreach (rows[i])
        begin
            periphIrqPending <= rows[i].per;
            debugHalted <= rows[i].dbg;
            releaseTakesIrq <= rows[i].rel;
            wrReg(INT_CTRL_OFFSET, rows[i].wd, 3'h1, rsp);
            check("bresp", 32'(RESP_OKAY), 32'(rsp));
            check("svc", 32'(rows[i].svc), 32'(servicePending));
            check("tick", 32'(rows[i].tick), 32'(tickPending));
            rdReg(INT_CTRL_OFFSET, 3'h1, rd, rsp);
            want = {3'h0, rows[i].svc, 1'b0, rows[i].tick, 2'h0,
                rows[i].dbg & rows[i].rel, |rows[i].per, 22'h0};
            check("ctrl", want, rd & 32'h15FC0000);
        end
        // ****
        // Refused accesses
        // ****
        wrReg(INT_CTRL_OFFSET, 32'h04000000, 3'h0, rsp);
        check("unpriv wr", 32'(RESP_SLVERR), 32'(rsp));
        wrReg(12'hD05, 32'h04000000, 3'h1, rsp);
        check("unaligned wr", 32'(RESP_SLVERR), 32'(rsp));
        check("tick kept", 32'h0, 32'(tickPending));
        wrReg(12'h100, 32'h0, 3'h1, rsp);
        check("unmapped wr", 32'(RESP_DECERR), 32'(rsp));
        rdReg(INT_CTRL_OFFSET, 3'h0, rd, rsp);
        check("unpriv rd", 32'(RESP_SLVERR), 32'(rsp));
        // ****
        // Events, mask and interrupt
        // ****
        wrReg(EVT_STATUS_OFFSET, 32'h7, 3'h1, rsp);
        wrReg(EVT_MASK_OFFSET, 32'h7, 3'h1, rsp);
        rdReg(EVT_MASK_OFFSET, 3'h1, rd, rsp);
        check("mask", 32'h7, rd);
        check("irq idle", 32'h0, 32'(irq));
        pulse(0);
        check("tick event", 32'h1, 32'(tickPending));
        check("irq set", 32'h1, 32'(irq));
        rdReg(EVT_STATUS_OFFSET, 3'h1, rd, rsp);
        check("status", 32'h1, rd);
        wrReg(EVT_STATUS_OFFSET, 32'h1, 3'h1, rsp);
        repeat (2) @(posedge core_clk);
        check("irq cleared", 32'h0, 32'(irq));
        pulse(1);
        check("tick ack", 32'h0, 32'(tickPending));
        wrReg(EVT_MASK_OFFSET, 32'h0, 3'h1, rsp);
        wrReg(INT_CTRL_OFFSET, 32'h10000000, 3'h1, rsp);
        pulse(0);
        check("irq masked", 32'h0, 32'(irq));
        pulse(2);
        check("svc ack", 32'h0, 32'(servicePending));
        // ****
        // Reset in mid-run
        // ****
        rst_n <= 1'b0;
        @(posedge core_clk);
        check("rst tick", 32'h0, 32'(tickPending));
        rst_n <= 1'b1;
        rdReg(EVT_STATUS_OFFSET, 3'h1, rd, rsp);
        check("rst status", 32'h0, rd);
        endSim();
    end

    // Bound on the whole run, far above the roughly 130 cycles needed
    initial
    begin
        repeat (5000) @(posedge core_clk);
        badCount++;
        endSim();
    end
endmodule : tb_top
`default_nettype wire
